// >>> hw/plf_readout.sv
// Purpose: float measurand readout with sticky limit status word
// Assumes: one 250 MHz clock, synchronous active-high reset, same-clock host
// Notes: the host selects a measurand by id; word leaves msb byte first
//
// Overview of operation
// - return value only for requested id; 41=status
// - energy counters clamp to 0..5.49705e8 Wh
// - overflow counters 39 and 40 inactive
// - total power magnitude saturates at 3.75e6, sign kept
// - status flags refresh when data set advances
// - flags stay set until acknowledged
// - acknowledge also switches off limit lamps
// - status word sent high byte first
// - byte 0: voltage, temperature, frequency flags
// - byte 1: current, power factor, L1 undervoltage
// - reset-seen bit set by reset, ack 0x04 clears
// - one measurement shares data set id 1..15
`timescale 1ns/100ps
`default_nettype none
module plf_readout
	import plf_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESET_I,
	// measurement front end
	input wire logic MEAS_STROBE_I, // one pulse per finished measurement
	input wire logic [31:0] MEAS_VALUE_I, // float value for MEAS_ID_I
	input wire logic [5:0] MEAS_ID_I, // id being written this cycle
	input wire logic MEAS_WE_I, // write of one measurand value
	input wire logic [COND_W-1:0] LIMIT_COND_I, // live limit conditions
	// host request
	input wire logic REQ_VALID_I, // read request pulse
	input wire logic [5:0] REQ_ID_I, // requested measurand id
	input wire logic CMD_VALID_I, // frame command pulse
	input wire logic [7:0] CMD_CODE_I, // frame command code
	// host response
	output logic RSP_VALID_O, // one byte of response valid
	output logic [7:0] RSP_BYTE_O, // response byte, msb first
	output logic RSP_LAST_O, // last byte of the word
	output logic RSP_ERR_O, // id not available
	output logic [3:0] DSID_O, // current data set identifier
	output logic [COND_W-1:0] LAMP_O // limit indicator lamps
);
	// ***********************************************************
	// measurand store
	// ***********************************************************
	logic [31:0] meas_mem [0:NUM_MEASURANDS]; // value per id, slot 0 unused
	logic [31:0] wr_value; // clamped value to store
	wire wr_energy = (MEAS_ID_I >= ID_ENERGY_FIRST) && (MEAS_ID_I <= ID_ENERGY_LAST);
	wire wr_power = (MEAS_ID_I >= ID_TOTAL_ACTIVE) && (MEAS_ID_I <= ID_TOTAL_APPARENT);
	wire wr_ovfl = (MEAS_ID_I == ID_OVFL_CONSUMER) || (MEAS_ID_I == ID_OVFL_PRODUCER);
	wire in_sign = MEAS_VALUE_I[FLT_SIGN_BIT];
	wire [30:0] in_mag = MEAS_VALUE_I[30:0] & FLT_MAG_MASK;
	wire energy_hi = in_mag > FLT_ENERGY_MAX[30:0];
	wire power_hi = in_mag > FLT_POWER_MAX[30:0];
	// positive float magnitudes order like integers, so compare bits directly
	always_comb begin
		wr_value = MEAS_VALUE_I;
		if (wr_energy) begin
			if (in_sign) begin
				wr_value = FLT_ZERO;
			end else if (energy_hi) begin
				wr_value = FLT_ENERGY_MAX;
			end
		end else if (wr_power && power_hi) begin
			wr_value = {in_sign, FLT_POWER_MAX[30:0]};
		end else if (wr_ovfl) begin
			wr_value = FLT_ZERO;
		end
	end
	wire wr_ok = MEAS_WE_I && (MEAS_ID_I != 6'h00) && (MEAS_ID_I < ID_STATUS);
	// store one value; no reset since contents are only data
	always_ff @(posedge CORE_CLK_I) begin
		if (wr_ok) begin
			meas_mem[MEAS_ID_I] <= wr_value;
		end
	end
	// ***********************************************************
	// data set identifier
	// ***********************************************************
	logic [3:0] dsid_reg;
	wire [3:0] dsid_next = (dsid_reg == DSID_LAST) ? DSID_FIRST : dsid_reg + 4'h1;
	// wraps 15 to 1, never shows 0
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			dsid_reg <= DSID_FIRST;
		end else if (MEAS_STROBE_I) begin
			dsid_reg <= dsid_next;
		end
	end
	assign DSID_O = dsid_reg;
	// ***********************************************************
	// sticky limit flags
	// ***********************************************************
	logic [COND_W-1:0] flags; // sticky status bits 15:0
	wire ack = CMD_VALID_I && (CMD_CODE_I == CMD_ACK_STATUS);
	// conditions sampled only on refresh, so flags move with the data set
	wire [COND_W-1:0] set_vec = MEAS_STROBE_I ? LIMIT_COND_I : '0;
	genvar g;
	generate
		for (g = 0; g < COND_W; g++) begin : g_flag
			if (g == ST_RESET_SEEN) begin : g_rst
				plf_sticky_flag u_flag (
					.clk_i(CORE_CLK_I),
					.rst_i(RESET_I),
					.rst_val_i(1'b1),
					.set_i(1'b0),
					.ack_i(ack),
					.flag_o(flags[g])
				);
			end else begin : g_lim
				plf_sticky_flag u_flag (
					.clk_i(CORE_CLK_I),
					.rst_i(RESET_I),
					.rst_val_i(1'b0),
					.set_i(set_vec[g]),
					.ack_i(ack),
					.flag_o(flags[g])
				);
			end
		end
	endgenerate
	// bit order of byte 0 and byte 1 is the condition vector order
	wire [31:0] status_word = {STATUS_UPPER_ZERO, flags};
	// lamps follow the flags one cycle later, so ack darkens them too
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			LAMP_O <= '0;
		end else begin
			LAMP_O <= flags;
		end
	end
	// ***********************************************************
	// response serialiser
	// ***********************************************************
	plf_state_e state_reg;
	logic [31:0] shift_reg; // word being sent
	logic [1:0] idx_reg; // byte counter
	wire req_ok = (REQ_ID_I != 6'h00) && (REQ_ID_I <= ID_STATUS);
	wire [31:0] sel_word = (REQ_ID_I == ID_STATUS) ? status_word : meas_mem[REQ_ID_I];
	// requests arriving while a word is in flight are ignored
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			state_reg <= PLF_IDLE;
			shift_reg <= '0;
			idx_reg <= '0;
			RSP_VALID_O <= 1'b0;
			RSP_BYTE_O <= '0;
			RSP_LAST_O <= 1'b0;
			RSP_ERR_O <= 1'b0;
		end else begin
			RSP_ERR_O <= 1'b0;
			case (state_reg)
				PLF_IDLE: begin
					RSP_VALID_O <= 1'b0;
					RSP_LAST_O <= 1'b0;
					if (REQ_VALID_I && req_ok) begin
						shift_reg <= sel_word;
						idx_reg <= '0;
						state_reg <= PLF_SEND;
					end else if (REQ_VALID_I) begin
						RSP_ERR_O <= 1'b1; // unknown id, no data
					end
				end
				PLF_SEND: begin
					RSP_VALID_O <= 1'b1;
					RSP_BYTE_O <= shift_reg[31 -: BYTE_W];
					shift_reg <= {shift_reg[23:0], 8'h00};
					RSP_LAST_O <= (idx_reg == BYTE_IDX_LAST);
					idx_reg <= idx_reg + 2'h1;
					if (idx_reg == BYTE_IDX_LAST) begin
						state_reg <= PLF_IDLE;
					end
				end
				default: begin
					state_reg <= PLF_IDLE;
				end
			endcase
		end
	end
	// ***********************************************************
	// checks
	// ***********************************************************
	sequence ack_seq;
		ack && !MEAS_STROBE_I;
	endsequence
	reset_flag_set_a: assert property (@(posedge CORE_CLK_I) $fell(RESET_I) |-> flags[ST_RESET_SEEN])
		else $error("reset-seen flag not set after reset");
	ack_clears_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ack_seq |=> (flags == '0))
		else $error("acknowledge did not clear flags");
	flag_sticky_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		(!ack) |=> ((flags & $past(flags)) == $past(flags)))
		else $error("flag cleared without acknowledge");
	refresh_set_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		(MEAS_STROBE_I && LIMIT_COND_I[ST_UV_L2]) |=> flags[ST_UV_L2])
		else $error("held condition not flagged on refresh");
	lamp_follow_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ack_seq |-> ##2 (LAMP_O == '0))
		else $error("lamps not cleared by acknowledge");
	upper_zero_a: assert property (@(posedge CORE_CLK_I) status_word[31:16] == STATUS_UPPER_ZERO)
		else $error("status bytes 2 and 3 not zero");
	dsid_range_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		(dsid_reg != 4'h0))
		else $error("data set identifier left range");
	status_msb_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		(state_reg == PLF_IDLE && REQ_VALID_I && REQ_ID_I == ID_STATUS)
		|-> ##2 (RSP_VALID_O && RSP_BYTE_O == 8'h00))
		else $error("status word not sent high byte first");
	power_sat_a: assert property (@(posedge CORE_CLK_I)
		wr_power |-> (wr_value[30:0] <= FLT_POWER_MAX[30:0]))
		else $error("total power not saturated");
	energy_cap_a: assert property (@(posedge CORE_CLK_I)
		wr_energy |-> (wr_value[30:0] <= FLT_ENERGY_MAX[30:0] && !wr_value[FLT_SIGN_BIT]))
		else $error("energy counter out of range");
	ovfl_zero_a: assert property (@(posedge CORE_CLK_I) wr_ovfl |-> (wr_value == FLT_ZERO))
		else $error("overflow counter active in float mode");
endmodule
`default_nettype wire

// >>> hw/plf_pkg.sv
// Purpose: shared constants for the measurand readout and limit flag block
// Assumes: one module clock, synchronous active-high reset
// Notes: identifiers, field positions and float limits live here only
package plf_pkg;
	// ***********************************************************
	// measurand identifiers
	// ***********************************************************
	localparam logic [5:0] ID_ENERGY_FIRST = 6'h01; // first energy counter
	localparam logic [5:0] ID_ENERGY_LAST = 6'h08; // last energy counter
	localparam logic [5:0] ID_TOTAL_ACTIVE = 6'h09; // total active power
	localparam logic [5:0] ID_TOTAL_APPARENT = 6'h0B; // last three-phase total
	localparam logic [5:0] ID_OVFL_CONSUMER = 6'h27; // overflow counter 39
	localparam logic [5:0] ID_OVFL_PRODUCER = 6'h28; // overflow counter 40
	localparam logic [5:0] ID_STATUS = 6'h29; // limit status word, 41
	localparam int NUM_MEASURANDS = 41; // count of measurand slots
	// ***********************************************************
	// data set identifier
	// ***********************************************************
	localparam logic [3:0] DSID_FIRST = 4'h1; // lowest data set identifier
	localparam logic [3:0] DSID_LAST = 4'hF; // highest data set identifier
	// ***********************************************************
	// float limits, ieee single encoding
	// ***********************************************************
	localparam logic [31:0] FLT_ENERGY_MAX = 32'h4E03_0F55; // 5.49705e8 Wh
	localparam logic [31:0] FLT_POWER_MAX = 32'h4A64_DE60; // 3.75e6
	localparam logic [31:0] FLT_ZERO = 32'h0000_0000; // float zero
	localparam logic [30:0] FLT_MAG_MASK = 31'h7FFF_FFFF; // magnitude bits
	localparam int FLT_SIGN_BIT = 31; // sign position
	// ***********************************************************
	// limit condition vector positions (status word bits 15:0)
	// ***********************************************************
	localparam int COND_W = 16; // width of condition vector
	localparam int ST_UV_L2 = 0; // phase 2 undervoltage
	localparam int ST_UV_L3 = 1; // phase 3 undervoltage
	localparam int ST_OV_L1 = 2; // phase 1 overvoltage
	localparam int ST_OV_L2 = 3; // phase 2 overvoltage
	localparam int ST_OV_L3 = 4; // phase 3 overvoltage
	localparam int ST_OVERTEMP = 5; // overtemperature
	localparam int ST_UNDERFREQ = 6; // underfrequency
	localparam int ST_OVERFREQ = 7; // overfrequency
	localparam int ST_RESET_SEEN = 8; // module went through reset
	localparam int ST_OC_L1 = 9; // phase 1 overcurrent
	localparam int ST_OC_L3 = 11; // phase 3 overcurrent
	localparam int ST_PF_L1 = 12; // phase 1 power factor low
	localparam int ST_PF_L3 = 14; // phase 3 power factor low
	localparam int ST_UV_L1 = 15; // phase 1 undervoltage
	localparam logic [15:0] STATUS_UPPER_ZERO = 16'h0000; // status bytes 2 and 3
	localparam logic [15:0] STATUS_RESET_VAL = 16'h0100; // reset-seen flag only
	// ***********************************************************
	// acknowledge command
	// ***********************************************************
	localparam logic [7:0] CMD_ACK_STATUS = 8'h04; // clears reset-seen and flags
	localparam int BYTE_W = 8; // width of one transferred byte
	localparam logic [1:0] BYTE_IDX_LAST = 2'h3; // last byte of a word
	typedef enum logic [1:0] {PLF_IDLE, PLF_SEND} plf_state_e;
endpackage

// >>> hw/plf_sticky_flag.sv
// Purpose: one sticky limit flag with acknowledge
// Assumes: set and ack come from logic on the same clock
// Notes: a set in the ack cycle wins, so no event is lost
`timescale 1ns/100ps
`default_nettype none
module plf_sticky_flag (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rst_val_i, // constant value taken under reset
	// control
	input wire logic set_i, // condition sampled on a refresh
	input wire logic ack_i, // acknowledge pulse
	// state
	output logic flag_o
);
	// ***********************************************************
	// flag store
	// ***********************************************************
	// set wins over ack; violation vanishing never clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= rst_val_i;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (ack_i) begin
			flag_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> test/plf_head_model.sv
// Purpose: head module model, issues reads and packs reply bytes
// Assumes: same clock as the readout block
// Notes: idle id lines toggle, never hold the last value
`timescale 1ns/100ps
`default_nettype none
module plf_head_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench control
	input wire logic go_i, // start one read
	input wire logic [5:0] id_i, // id to read
	// request
	output logic req_valid_o, // one-cycle request
	output logic [5:0] req_id_o, // requested id
	// response
	input wire logic rsp_valid_i, // byte strobe
	input wire logic [7:0] rsp_byte_i, // reply byte
	input wire logic rsp_last_i, // last byte
	output logic [31:0] word_o, // packed word
	output logic done_o // word complete
);
	// ****
	// request and packing
	// ****
	// shift from the bottom so the first byte ends on top
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_valid_o <= 1'b0;
			req_id_o <= 6'h00;
			word_o <= 32'h0000_0000;
			done_o <= 1'b0;
		end else begin
			req_valid_o <= go_i;
			req_id_o <= go_i ? id_i : ~req_id_o; // released lines move
			if (rsp_valid_i) begin
				word_o <= {word_o[23:0], rsp_byte_i};
			end
			done_o <= rsp_valid_i & rsp_last_i;
		end
	end
endmodule
`default_nettype wire

// >>> test/power_measurand_limit_flags_tb_top.sv
// Purpose: self-checking bench for the readout block
// Assumes: seed 66, 250 MHz clock
// Notes: expectations come from bench tasks and functions only
`timescale 1ns/100ps
`default_nettype none
module power_measurand_limit_flags_tb_top
	import plf_pkg::*;
;
	// ****
	// stimulus and observation
	// ****
	logic clk = 1'b0, rst = 1'b1, strobe = 1'b0, we = 1'b0, cmd_v = 1'b0, go = 1'b0;
	logic [31:0] value = 32'h0, v, r;
	logic [5:0] meas_id = 6'h0, id = 6'h0, mid;
	logic [15:0] cond = 16'h0, exp_flags;
	logic [7:0] cmd = 8'h0;
	logic [3:0] exp_dsid;
	wire logic req_v, rsp_v, rsp_last, rsp_err, done;
	wire logic [5:0] req_id;
	wire logic [7:0] rsp_byte;
	wire logic [3:0] dsid;
	wire logic [15:0] lamp;
	wire logic [31:0] word;
	int errors = 0, tests_run = 0, k;
	logic [5:0] cid [4] = '{6'h01, 6'h09, 6'h27, 6'h08}; // corner ids
	logic [31:0] cv [4] = '{32'h4E03_0F56, 32'hCA64_DE61, 32'h3F80_0000, 32'hBF80_0000};
	always #2 clk = ~clk;
	plf_readout plf_readout_inst (.CORE_CLK_I(clk), .RESET_I(rst), .MEAS_STROBE_I(strobe),
		.MEAS_VALUE_I(value), .MEAS_ID_I(meas_id), .MEAS_WE_I(we), .LIMIT_COND_I(cond),
		.REQ_VALID_I(req_v), .REQ_ID_I(req_id), .CMD_VALID_I(cmd_v), .CMD_CODE_I(cmd),
		.RSP_VALID_O(rsp_v), .RSP_BYTE_O(rsp_byte), .RSP_LAST_O(rsp_last),
		.RSP_ERR_O(rsp_err), .DSID_O(dsid), .LAMP_O(lamp));
	plf_head_model plf_head_model_inst (.clk_i(clk), .rst_i(rst), .go_i(go), .id_i(id),
		.req_valid_o(req_v), .req_id_o(req_id), .rsp_valid_i(rsp_v), .rsp_byte_i(rsp_byte),
		.rsp_last_i(rsp_last), .word_o(word), .done_o(done));
	// ****
	// helpers
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// one read; sampling on the falling edge keeps clear of update races
	task automatic rd(input logic [5:0] rid, output logic [31:0] w, input bit bad);
		logic e;
		logic s;
		e = 1'b0;
		s = 1'b0;
		@(posedge clk);
		go <= 1'b1;
		id <= rid;
		@(posedge clk);
		go <= 1'b0;
		repeat (8) begin
			@(negedge clk);
			e = e | (rsp_err === 1'b1);
			s = s | (done === 1'b1);
		end
		w = word;
		check({30'h0, e, s}, bad ? 32'h2 : 32'h1);
	endtask
	task automatic pulse(input logic [15:0] c, input bit ack, input logic [7:0] code);
		@(posedge clk);
		strobe <= !ack;
		cond <= c;
		cmd_v <= ack;
		cmd <= code;
		@(posedge clk);
		strobe <= 1'b0;
		cmd_v <= 1'b0;
		if (!ack) begin
			exp_flags = exp_flags | (c & 16'hFEFF);
			exp_dsid = (exp_dsid == DSID_LAST) ? DSID_FIRST : exp_dsid + 4'h1;
		end else if (code == CMD_ACK_STATUS) begin
			exp_flags = 16'h0000;
		end
	endtask
	function automatic logic [31:0] exp_meas(input logic [5:0] i, input logic [31:0] x);
		if (i >= ID_ENERGY_FIRST && i <= ID_ENERGY_LAST) begin
			if (x[31]) return FLT_ZERO;
			return (x[30:0] > FLT_ENERGY_MAX[30:0]) ? FLT_ENERGY_MAX : x;
		end
		if (i >= ID_TOTAL_ACTIVE && i <= ID_TOTAL_APPARENT) begin
			return (x[30:0] > FLT_POWER_MAX[30:0]) ? {x[31], FLT_POWER_MAX[30:0]} : x;
		end
		if (i == ID_OVFL_CONSUMER || i == ID_OVFL_PRODUCER) return FLT_ZERO;
		return x;
	endfunction
	// ****
	// main sequence
	// ****
	initial begin
		k = $urandom(66);
		exp_dsid = DSID_FIRST;
		exp_flags = STATUS_RESET_VAL;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(ID_STATUS, r, 0);
		check(r, {STATUS_UPPER_ZERO, exp_flags});
		pulse(16'h0, 1, 8'h04 ^ 8'($urandom_range(1, 255))); // wrong code keeps flags
		for (k = 0; k < 24; k++) begin
			pulse(16'($urandom), k % 6 == 5, CMD_ACK_STATUS);
			rd(ID_STATUS, r, 0);
			check(r, {STATUS_UPPER_ZERO, exp_flags});
			check({16'h0, lamp}, {16'h0, exp_flags});
			check({28'h0, dsid}, {28'h0, exp_dsid});
		end
		for (k = 0; k < 40; k++) begin
			mid = (k < 4) ? cid[k] : 6'($urandom_range(1, 40));
			v = (k < 4) ? cv[k] : $urandom;
			if (v[30:23] == 8'hFF) v[30] = 1'b0;
			@(posedge clk);
			we <= 1'b1;
			meas_id <= mid;
			value <= v;
			@(posedge clk);
			we <= 1'b0;
			value <= ~v;
			rd(mid, r, 0);
			check(r, exp_meas(mid, v));
		end
		rd(6'h00, r, 1);
		rd(6'($urandom_range(42, 63)), r, 1);
		finish_test();
	end
	// about 800 cycles are needed; 10000 cycles means a hang
	initial begin
		#40000;
		errors++;
		finish_test();
	end
endmodule
`default_nettype wire
